// ===== verification/btg_assertions.sv
// Port assertions of the tone generator
`include "btg_cfg.svh"
`default_nettype none
module btg_assertions #(
  parameter int ADR_W    = 24,
  parameter int HALF_DIV = 2
) (
  input wire logic             sys_clk_in,
  input wire logic             rst_n_in,
  input wire logic             wb_cyc_in,
  input wire logic             wb_stb_in,
  input wire logic             wb_we_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [3:0]       wb_sel_in,
  input wire logic [31:0]      wb_dat_in,
  input wire logic [31:0]      wb_dat_out,
  input wire logic             wb_ack_out,
  input wire logic             tone_pin_out
);
  logic       pa;
  logic       ca;
  logic [7:0] shadow;
  logic [7:0] hi_cnt;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  assign pa = wb_adr_in == ADR_W'(`BTG_REG_PITCH_IDX * 4);
  assign ca = wb_adr_in == ADR_W'(`BTG_REG_CTRL_IDX * 4);
  // Pitch register copy and length of the high phase
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shadow <= 8'h00;
      hi_cnt <= 8'h00;
    end else begin
      if (wb_ack_out && wb_we_in && wb_sel_in[0] && pa)
        shadow <= wb_dat_in[7:0] & 8'h77;
      hi_cnt <= tone_pin_out ? hi_cnt + 8'h01 : 8'h00;
    end
  end
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_rd;
    wb_ack_out && !wb_we_in;
  endsequence
  property p_ack_resp; s_req |=> wb_ack_out; endproperty
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  property p_no_spur; !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out; endproperty
  property p_dat_hi; wb_ack_out |-> wb_dat_out[31:8] == 24'h0; endproperty
  property p_ctrl_zero; s_rd ##0 ca |-> (wb_dat_out[7:0] & 8'hc4) == 8'h00; endproperty
  property p_pitch_rb; s_rd ##0 pa |-> wb_dat_out[7:0] == shadow; endproperty
  property p_rst_low; $rose(rst_n_in) |-> !tone_pin_out [*8]; endproperty
  property p_hi_max; hi_cnt <= 8'(24 * HALF_DIV); endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_no_spur: assert property (p_no_spur) else $error("ack without request");
  a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("command bit read back");
  a_pitch_rb: assert property (p_pitch_rb) else $error("pitch readback wrong");
  a_rst_low: assert property (p_rst_low) else $error("pin active after reset");
  a_hi_max: assert property (p_hi_max) else $error("high phase too long");
endmodule
`default_nettype wire

// ===== verification/btg_buzzer_model.sv
// External buzzer: times the tone pin
`default_nettype none
module btg_buzzer_model (
  input  wire logic        sys_clk_in,
  input  wire logic        tone_in,
  output logic      [7:0]  period_out,
  output logic      [7:0]  high_out,
  output logic      [15:0] rises_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt  = 8'h00;
  logic       prev = 1'b0;
  initial period_out = 8'h00;
  initial high_out = 8'h00;
  initial rises_out = 16'h0000;
  // Pin is taken as pure tone, port data held at zero by software
  always @(posedge sys_clk_in) begin
    prev <= tone_in;
    cnt  <= cnt + 8'h01;
    if (tone_in && !prev) begin
      period_out <= cnt;
      cnt        <= 8'h01;
      rises_out  <= rises_out + 16'h0001;
    end
    if (!tone_in && prev)
      high_out <= cnt;
  end
endmodule
`default_nettype wire

// ===== verification/btg_top_tb.sv
// Self-checking bench of the tone generator
`include "btg_cfg.svh"
`default_nettype none
module btg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          HD = 2;
  localparam int          TK = 512;
  localparam logic [23:0] CA = 24'(`BTG_REG_CTRL_IDX * 4);
  localparam logic [23:0] PA = 24'(`BTG_REG_PITCH_IDX * 4);
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [23:0] adr = 24'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dw = 32'h0, dout, rdat, rs = 32'h10;
  logic        ack, pin;
  logic [7:0]  per, hi;
  logic [15:0] rises, r0;
  int          error_cnt = 0, checks = 0;
  time         t0;
  always #20 clk = ~clk;
  btg_top #(.HALF_DIV(HD)) btg_top_inst (.sys_clk_in(clk), .rst_n_in(rst_n),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(dw), .wb_dat_out(dout), .wb_ack_out(ack), .tone_pin_out(pin));
  btg_buzzer_model btg_buzzer_model_inst (.sys_clk_in(clk), .tone_in(pin),
    .period_out(per), .high_out(hi), .rises_out(rises));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic int nd(input int c);
    return c < 4 ? 8 + 2 * c : 16 + 4 * (c - 4);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [23:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dw  <= {24'h0, d};
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dout;
    if (n >= 20)
      error_cnt++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rchk(input logic [23:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'hf);
    chk(rdat, exp);
  endtask
  // Wait for three fresh rising edges of the tone
  task automatic settle;
    int n;
    n = 0;
    r0 = rises;
    while (16'(rises - r0) < 16'd3 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000)
      error_cnt++;
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(CA, 32'h0);
    rchk(PA, 32'h0);
    rchk(24'h000100, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rs = xs(rs);
      wr(PA, rs[7:0]);
      rchk(PA, {24'h0, rs[7:0] & 8'h77});
    end
    bus(1'b1, PA, ~rs[7:0], 4'h0);
    rchk(PA, {24'h0, rs[7:0] & 8'h77});
    wr(CA, 8'h9a);
    rchk(CA, 32'h1a);
    wr(CA, 8'h04);
    rchk(CA, 32'h0);
    wr(CA, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(PA, 8'(c));
      settle;
      chk({24'h0, per}, 32'(2 * nd(c) * HD));
      chk({24'h0, hi}, 32'((c < 4 ? 1 : 2) * ((c % 4) < 2 ? 8 : 12) * HD));
    end
    for (int l = 0; l < 8; l++) begin
      wr(PA, {1'b0, 3'(l), 4'h0});
      settle;
      chk({24'h0, hi}, 32'((8 - l) * HD));
    end
    wr(CA, 8'h00);
    repeat (4) @(posedge clk);
    r0 = rises;
    repeat (300) @(posedge clk);
    chk({16'h0, rises}, {16'h0, r0});
    t0 = $time;
    wr(CA, 8'h22);
    rchk(CA, 32'h20);
    for (int i = 0; i < 3000 && rdat[5] === 1'b1; i++)
      bus(1'b0, CA, 8'h00, 4'hf);
    chk(rdat, 32'h0);
    chk(32'(($time - t0) / 40 >= 8 * TK && ($time - t0) / 40 <= 10 * TK), 32'h1);
    chk(32'(rises != r0), 32'h1);
    wr(CA, 8'h30);
    repeat (20 * TK) @(posedge clk);
    wr(CA, 8'h30);
    repeat (20 * TK) @(posedge clk);
    rchk(CA, 32'h30);
    wr(CA, 8'h50);
    rchk(CA, 32'h10);
    wr(CA, 8'h70);
    rchk(CA, 32'h10);
    wr(CA, 8'h21);
    rchk(CA, 32'h01);
    wr(PA, 8'h70);
    wr(CA, 8'h03);
    settle;
    chk({24'h0, hi}, 32'(8 * HD));
    repeat (20 * TK) @(posedge clk);
    settle;
    chk(32'(hi < 8'(8 * HD)), 32'h1);
    wr(CA, 8'h07);
    settle;
    chk({24'h0, hi}, 32'(8 * HD));
    // Slow steps: no step after 20 ticks, one step after 36
    wr(CA, 8'h0b);
    repeat (20 * TK) @(posedge clk);
    settle;
    chk({24'h0, hi}, 32'(8 * HD));
    repeat (16 * TK) @(posedge clk);
    settle;
    chk({24'h0, hi}, 32'(7 * HD));
    finish_test;
  end
  // Watchdog well past the planned run
  initial begin
    #(40 * 100000);
    error_cnt++;
    finish_test;
  end
endmodule
bind btg_top btg_assertions #(.ADR_W(ADR_W), .HALF_DIV(HALF_DIV)) btg_assertions_inst (
  .sys_clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
  .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .tone_pin_out);
`default_nettype wire

// ===== verilog/btg_cfg.svh
// Offsets, field positions, reset values and timing figures of the tone generator
`ifndef BTG_CFG_SVH
`define BTG_CFG_SVH

// ----------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------
`define BTG_REG_CTRL_IDX      22'h00ff44
`define BTG_REG_PITCH_IDX     22'h00ff45

// ----------------------------------------
// tone_control field positions
// ----------------------------------------
`define BTG_CTRL_ENABLE_BIT   0
`define BTG_CTRL_DECAY_BIT    1
`define BTG_CTRL_RESTART_BIT  2
`define BTG_CTRL_STEP_BIT     3
`define BTG_CTRL_LEN_BIT      4
`define BTG_CTRL_TRIG_BIT     5
`define BTG_CTRL_ABORT_BIT    6

// ----------------------------------------
// tone_pitch_level field positions
// ----------------------------------------
`define BTG_PITCH_LSB         0
`define BTG_LEVEL_LSB         4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BTG_RST_BIT           1'b0
`define BTG_RST_CODE          3'h0

// ----------------------------------------
// Timing figures
// ----------------------------------------
`define BTG_TICK_HZ           256
`define BTG_HALVES_PER_TICK   256
`define BTG_BURST_LONG_US     125000
`define BTG_BURST_SHORT_US    31250
`define BTG_STEP_SLOW_US      125000
`define BTG_STEP_FAST_US      62500
`define BTG_US_PER_S          1000000
`define BTG_SYS_CLK_HZ        25000000
`define BTG_OSC_HALF_HZ       65536

`endif

// ===== verilog/btg_pkg.sv
// Shared types of the tone generator
`default_nettype none
package btg_pkg;
  typedef logic [2:0] btg_code_t;
  typedef logic [5:0] btg_halves_t;
  typedef logic [7:0] btg_byte_t;
endpackage
`default_nettype wire

// ===== verilog/btg_tone_gen.sv
// Square wave generator counting half oscillator periods
`default_nettype none
module btg_tone_gen
  import btg_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  btg_tone_if.gen   tone
);
  btg_halves_t phase;
  btg_halves_t period;
  btg_halves_t high;
  logic [4:0]  base;
  logic [3:0]  num;

  // ----------------------------------------
  // Period and high time from pitch and level
  // ----------------------------------------
  // Base of 16, 20, 24 or 28 halves; upper pitch codes double it
  always_comb begin
    base   = 5'(5'd16 + {tone.pitch[1:0], 2'b00});
    num    = 4'((tone.pitch[1] ? 4'd12 : 4'd8) - {1'b0, tone.level});
    period = tone.pitch[2] ? {base, 1'b0} : {1'b0, base};
    high   = tone.pitch[2] ? {1'b0, num, 1'b0} : {2'b00, num};
  end

  // Phase counter in half oscillator periods
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase <= '0;
    end else if (tone.half_en) begin
      phase <= (phase >= period - 6'd1) ? '0 : phase + 6'd1;
    end
  end

  // Waveform high for the first part of each period
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tone.wave <= 1'b0;
    end else begin
      tone.wave <= (phase < high);
    end
  end
endmodule
`default_nettype wire

// ===== verilog/btg_tone_if.sv
// Link between the control logic and the waveform generator
`default_nettype none
interface btg_tone_if;
  import btg_pkg::*;
  logic      half_en;
  btg_code_t pitch;
  btg_code_t level;
  logic      wave;
  modport gen (input half_en, input pitch, input level, output wave);
  modport ctl (output half_en, output pitch, output level, input wave);
endinterface
`default_nettype wire

// ===== verilog/btg_top.sv
// Buzzer tone generator with Wishbone registers, decay envelope and timed bursts
//
// Chosen here: the Wishbone interface to the registers.
`include "btg_cfg.svh"
`default_nettype none
module btg_top
  import btg_pkg::*;
#(
  parameter int ADR_W    = 24,
  parameter int HALF_DIV = `BTG_SYS_CLK_HZ / `BTG_OSC_HALF_HZ
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             wb_cyc_in,
  input  wire logic             wb_stb_in,
  input  wire logic             wb_we_in,
  input  wire logic [ADR_W-1:0] wb_adr_in,
  input  wire logic [3:0]       wb_sel_in,
  input  wire logic [31:0]      wb_dat_in,
  output logic      [31:0]      wb_dat_out,
  output logic                  wb_ack_out,
  output logic                  tone_pin_out
);
  // ----------------------------------------
  // Derived counts
  // ----------------------------------------
  localparam int BURST_LONG  = `BTG_BURST_LONG_US * `BTG_TICK_HZ / `BTG_US_PER_S;
  localparam int BURST_SHORT = `BTG_BURST_SHORT_US * `BTG_TICK_HZ / `BTG_US_PER_S;
  localparam int STEP_SLOW   = `BTG_STEP_SLOW_US * `BTG_TICK_HZ / `BTG_US_PER_S;
  localparam int STEP_FAST   = `BTG_STEP_FAST_US * `BTG_TICK_HZ / `BTG_US_PER_S;

  generate
    if (HALF_DIV < 1 || HALF_DIV > 65536 || ADR_W < 20 || ADR_W > 32) begin : g_bad
      $error("btg_top: unsupported HALF_DIV or ADR_W");
    end
  endgenerate

  btg_tone_if tone ();

  logic [15:0] half_cnt;
  logic [7:0]  halves;
  logic        tick_en;
  logic        tone_out_enable;
  logic        decay_enable;
  logic        decay_step_select;
  logic        burst_length_select;
  logic        burst_busy;
  logic        burst_on;
  logic [5:0]  burst_cnt;
  logic [5:0]  step_cnt;
  btg_code_t   pitch_select;
  btg_code_t   level_select;
  btg_code_t   env_level;
  logic        req;
  logic        wr;
  logic        hit_ctrl;
  logic        hit_pitch;
  logic        wr_ctrl;
  logic        trig_wr;
  logic        abort_wr;
  logic        restart_wr;
  btg_byte_t   rd_byte;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  // Half oscillator period enable and 256 Hz tick
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      half_cnt     <= '0;
      halves       <= '0;
      tone.half_en <= 1'b0;
      tick_en      <= 1'b0;
    end else begin
      tone.half_en <= 1'b0;
      tick_en      <= 1'b0;
      if (half_cnt >= 16'(HALF_DIV - 1)) begin
        half_cnt     <= '0;
        tone.half_en <= 1'b1;
        halves       <= halves + 8'd1;
        tick_en      <= (halves == 8'(`BTG_HALVES_PER_TICK - 1));
      end else begin
        half_cnt <= half_cnt + 16'd1;
      end
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // Writes land in the cycle that raises ack
  assign req        = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr         = req & wb_we_in & wb_sel_in[0];
  assign hit_ctrl   = (wb_adr_in[ADR_W-1:2] == (ADR_W-2)'(`BTG_REG_CTRL_IDX));
  assign hit_pitch  = (wb_adr_in[ADR_W-1:2] == (ADR_W-2)'(`BTG_REG_PITCH_IDX));
  assign wr_ctrl    = wr & hit_ctrl;
  assign abort_wr   = wr_ctrl & wb_dat_in[`BTG_CTRL_ABORT_BIT];
  // Trigger honoured only with normal output off
  assign trig_wr    = wr_ctrl & wb_dat_in[`BTG_CTRL_TRIG_BIT]
                    & ~wb_dat_in[`BTG_CTRL_ENABLE_BIT];
  assign restart_wr = wr_ctrl & wb_dat_in[`BTG_CTRL_RESTART_BIT];

  // Read data, restart and abort bits and gaps read zero, trigger bit reads busy
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctrl) begin
      rd_byte = {2'b00, burst_busy, burst_length_select, decay_step_select,
                 1'b0, decay_enable, tone_out_enable};
    end else if (hit_pitch) begin
      rd_byte = {1'b0, level_select, 1'b0, pitch_select};
    end
  end

  // Ack one cycle after request, unmapped reads zero
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      if (req) begin
        wb_dat_out <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Plain settings of tone_control
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tone_out_enable     <= `BTG_RST_BIT;
      decay_step_select   <= `BTG_RST_BIT;
      burst_length_select <= `BTG_RST_BIT;
    end else if (wr_ctrl) begin
      tone_out_enable     <= wb_dat_in[`BTG_CTRL_ENABLE_BIT];
      decay_step_select   <= wb_dat_in[`BTG_CTRL_STEP_BIT];
      burst_length_select <= wb_dat_in[`BTG_CTRL_LEN_BIT];
    end
  end

  // Decay enable, cleared when a burst starts
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      decay_enable <= `BTG_RST_BIT;
    end else if (trig_wr & ~abort_wr) begin
      decay_enable <= 1'b0;
    end else if (wr_ctrl) begin
      decay_enable <= wb_dat_in[`BTG_CTRL_DECAY_BIT];
    end
  end

  // Pitch and level settings
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pitch_select <= `BTG_RST_CODE;
      level_select <= `BTG_RST_CODE;
    end else if (wr & hit_pitch) begin
      pitch_select <= wb_dat_in[`BTG_PITCH_LSB +: 3];
      level_select <= wb_dat_in[`BTG_LEVEL_LSB +: 3];
    end
  end

  // ----------------------------------------
  // Timed burst
  // ----------------------------------------
  // Starts and ends on the 256 Hz tick, abort acts at once
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      burst_busy <= 1'b0;
      burst_on   <= 1'b0;
      burst_cnt  <= '0;
    end else if (abort_wr) begin
      burst_busy <= 1'b0;
      burst_on   <= 1'b0;
      burst_cnt  <= '0;
    end else if (trig_wr) begin
      burst_busy <= 1'b1;
      burst_cnt  <= burst_length_select_next();
    end else if (tick_en & burst_busy) begin
      if (!burst_on) begin
        burst_on <= 1'b1;
      end else if (burst_cnt <= 6'd1) begin
        burst_busy <= 1'b0;
        burst_on   <= 1'b0;
        burst_cnt  <= '0;
      end else begin
        burst_cnt <= burst_cnt - 6'd1;
      end
    end
  end

  // Length chosen by the value written with the trigger
  function automatic logic [5:0] burst_length_select_next();
    return wb_dat_in[`BTG_CTRL_LEN_BIT] ? 6'(BURST_LONG) : 6'(BURST_SHORT);
  endfunction

  // ----------------------------------------
  // Decay envelope
  // ----------------------------------------
  // Level climbs on each step, held at level 7
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      env_level <= 3'h0;
      step_cnt  <= '0;
    end else if (!tone_out_enable || !decay_enable || (restart_wr & decay_enable)) begin
      env_level <= 3'h0;
      step_cnt  <= '0;
    end else if (tick_en) begin
      if (step_cnt >= 6'((decay_step_select ? STEP_SLOW : STEP_FAST) - 1)) begin
        step_cnt <= '0;
        if (env_level != 3'h7) begin
          env_level <= env_level + 3'h1;
        end
      end else begin
        step_cnt <= step_cnt + 6'd1;
      end
    end
  end

  // ----------------------------------------
  // Waveform and pin
  // ----------------------------------------
  assign tone.pitch = pitch_select;
  assign tone.level = decay_enable ? env_level : level_select;

  btg_tone_gen u_gen (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .tone       (tone)
  );

  // Pin carries the wave only while output is on or a burst is running
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tone_pin_out <= 1'b0;
    end else begin
      tone_pin_out <= tone.wave & (tone_out_enable | burst_on);
    end
  end
endmodule
`default_nettype wire
